// ### hw/lvdr_top.sv
// Low voltage detector and low voltage reset supervisor, APB slave.
// Assumes comparator outputs are asynchronous levels and the core samples
// the halt, wake, interrupt and reset outputs on clk.
//
// How it works
// - Two-bit option picks brownout levels or none
// - Bit 7 bank 0 reads live state
// - Bit 6 flag, cleared by software or hardware
// - Bit 0 enables wake on detection
// - Bank 1 bit 7 gates the vector request, not irq
// - Bank 1 bit 6 enables detector
// - Bank 1 bits 5-4 pick threshold
// - Crossing while enabled sets the flag
// - Core vectors when flag, enable, global on
// - Flag set only below detection level
// - Detector runs in sleep, wakes core
// - System reset clears the flag
// - Short dip halts, keeps registers
// - Dip over 80 us forces reset
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module lvdr_top
#(
    parameter int GRACE_CYCLES = lvdr_pkg::GRACE_CYC // Brownout grace count
)
(
    input wire logic clk, // System clock, 20 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] brownout_level, // One-time option code
    input wire logic [3:0] det_below, // Comparators, one per level, high when at or below
    input wire logic [3:0] bor_below, // Brownout comparators, one per option
    input wire logic [3:0] bor_above, // Release comparators, one per option
    input wire logic core_sleeping, // Core is in sleep or idle
    output logic irq, // Level interrupt to the core
    output logic vector_req, // Core must take the vector next
    output logic wake_req, // Wake the core from sleep
    output logic halt_req, // Halt execution, keep state
    output logic sys_reset_req // Full system reset request
);

    // Elaboration check: the dip counter below is only 16 bits wide
    if (GRACE_CYCLES < 1 || GRACE_CYCLES > 65535)
    begin
        $error("GRACE_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: three stages, change counts when stages 2 and 3 agree

    logic [11:0] s1_q; // First stage, read only by stage 2
    logic [11:0] s2_q; // Second stage
    logic [11:0] s3_q; // Third stage
    logic [11:0] clean_q; // Filtered levels
    logic [11:0] raw;
    assign raw = {bor_above, bor_below, det_below};

    // Three flops, then accept only a settled value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 12'h000;
            s2_q <= 12'h000;
            s3_q <= 12'h000;
            clean_q <= 12'h000;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 12; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    clean_q[i] <= s3_q[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic wake_en_q; // Wake-up enable
    logic irq_flag_q; // Low voltage request flag
    logic irq_en_q; // Individual interrupt enable
    logic det_on_q; // Detector enable
    logic [1:0] level_q; // Detection level code
    logic [2:0] status_q; // Sticky event bits
    logic [2:0] mask_q; // Event mask
    logic gie_q; // Global interrupt on
    logic below_q; // Delayed state for edge
    logic [1:0] bor_opt_q; // Option captured after reset

    // Pick the comparator for a level code
    function automatic logic pick(input logic [3:0] v, input logic [1:0] code);
        pick = v[code];
    endfunction

    logic below; // Live: at or below level while enabled
    assign below = det_on_q & pick(clean_q[3:0], level_q);
    logic crossing;
    assign crossing = below & ~below_q;

    logic wr;
    logic rd;
    assign wr = psel & penable & pwrite & pready;
    assign rd = psel & penable & ~pwrite & pready;

    // Write enables
    logic wr_ctrl;
    logic wr_enlvl;
    logic wr_stat;
    logic wr_mask;
    logic wr_gie;
    assign wr_ctrl = wr && paddr == lvdr_pkg::OFF_CTRL_STATUS;
    assign wr_enlvl = wr && paddr == lvdr_pkg::OFF_ENABLE_LEVEL;
    assign wr_stat = wr && paddr == lvdr_pkg::OFF_IRQ_STATUS;
    assign wr_mask = wr && paddr == lvdr_pkg::OFF_IRQ_MASK;
    assign wr_gie = wr && paddr == lvdr_pkg::OFF_GLOBAL_IRQ;

    // Bank 1: enable and level, plain read/write
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_en_q <= lvdr_pkg::ENLVL_RESET[lvdr_pkg::IRQ_EN_BIT];
            det_on_q <= lvdr_pkg::ENLVL_RESET[lvdr_pkg::DET_ON_BIT];
            level_q <= lvdr_pkg::ENLVL_RESET[lvdr_pkg::LEVEL_HI_BIT:lvdr_pkg::LEVEL_LO_BIT];
        end
        else if (wr_enlvl)
        begin
            irq_en_q <= pwdata[lvdr_pkg::IRQ_EN_BIT];
            det_on_q <= pwdata[lvdr_pkg::DET_ON_BIT];
            level_q <= pwdata[lvdr_pkg::LEVEL_HI_BIT:lvdr_pkg::LEVEL_LO_BIT];
        end
    end

    // Bank 0 wake enable
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wake_en_q <= lvdr_pkg::CTRL_RESET[lvdr_pkg::WAKE_EN_BIT];
        else if (wr_ctrl)
            wake_en_q <= pwdata[lvdr_pkg::WAKE_EN_BIT];
    end

    // Request flag: crossing wins over a software clear; reset clears it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_flag_q <= 1'b0;
            below_q <= 1'b0;
        end
        else
        begin
            below_q <= below;
            if (crossing)
                irq_flag_q <= 1'b1;
            else if (wr_ctrl && !pwdata[lvdr_pkg::IRQ_FLAG_BIT])
                irq_flag_q <= 1'b0;
        end
    end

    // Global interrupt switch, standing in for enable and disable instructions
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            gie_q <= 1'b0;
        else if (wr_gie)
            gie_q <= pwdata[lvdr_pkg::GIE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Brownout supervisor

    typedef enum logic [1:0] {BOR_IDLE, BOR_DIP, BOR_RESET} lvdr_bor_t;
    lvdr_bor_t bor_st_q;
    logic [15:0] dip_cnt_q; // Cycles spent below reset level
    logic opt_taken_q; // Option latched since reset release

    // Option caught by a clock after release, not by the reset itself
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            opt_taken_q <= 1'b0;
            bor_opt_q <= lvdr_pkg::BOR_OFF;
        end
        else if (!opt_taken_q)
        begin
            opt_taken_q <= 1'b1;
            bor_opt_q <= brownout_level;
        end
    end

    logic bor_low;
    logic bor_ok;
    assign bor_low = bor_opt_q != lvdr_pkg::BOR_OFF && pick(clean_q[7:4], bor_opt_q);
    assign bor_ok = pick(clean_q[11:8], bor_opt_q);

    // Short dips halt; a dip longer than the grace time resets the system.
    // The reset request holds until the supply is back above release level.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bor_st_q <= BOR_IDLE;
            dip_cnt_q <= 16'h0000;
        end
        else
        begin
            case (bor_st_q)
                BOR_IDLE:
                begin
                    dip_cnt_q <= 16'h0000;
                    if (bor_low)
                        bor_st_q <= BOR_DIP;
                end
                BOR_DIP:
                begin
                    if (!bor_low)
                        bor_st_q <= BOR_IDLE;
                    else if (dip_cnt_q >= 16'(GRACE_CYCLES - 1))
                        bor_st_q <= BOR_RESET;
                    else
                        dip_cnt_q <= dip_cnt_q + 16'h0001;
                end
                BOR_RESET:
                begin
                    if (!bor_low && bor_ok)
                        bor_st_q <= BOR_IDLE;
                end
                default:
                    bor_st_q <= BOR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, mask and outputs

    logic [2:0] events;
    assign events = {bor_st_q == BOR_DIP && bor_low && dip_cnt_q >= 16'(GRACE_CYCLES - 1),
        crossing & wake_en_q & core_sleeping, crossing};

    // Events set bits; write-one clears, but a set in the same cycle wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status_q <= 3'h0;
            mask_q <= 3'h0;
        end
        else
        begin
            status_q <= (status_q & ~(wr_stat ? pwdata[2:0] : 3'h0)) | events;
            if (wr_mask)
                mask_q <= pwdata[2:0];
        end
    end

    // Core-facing outputs, registered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
            vector_req <= 1'b0;
            wake_req <= 1'b0;
            halt_req <= 1'b0;
            sys_reset_req <= 1'b0;
        end
        else
        begin
            irq <= |(status_q & mask_q);
            vector_req <= irq_flag_q & irq_en_q & gie_q;
            wake_req <= irq_flag_q & wake_en_q & core_sleeping;
            halt_req <= bor_st_q == BOR_DIP;
            sys_reset_req <= bor_st_q == BOR_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, unmapped reads zero with error

    logic mapped;
    assign mapped = paddr == lvdr_pkg::OFF_CTRL_STATUS || paddr == lvdr_pkg::OFF_ENABLE_LEVEL
        || paddr == lvdr_pkg::OFF_IRQ_STATUS || paddr == lvdr_pkg::OFF_IRQ_MASK
        || paddr == lvdr_pkg::OFF_GLOBAL_IRQ;

    // Ready comes one cycle into the access phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pready <= 1'b0;
        else
            pready <= psel & penable & ~pready;
    end

    // Error flag raised with ready for unmapped addresses
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pslverr <= 1'b0;
        else
            pslverr <= psel & penable & ~pready & ~mapped;
    end

    // Read data prepared in the cycle before ready
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel & penable & ~pready)
        begin
            case (paddr)
                lvdr_pkg::OFF_CTRL_STATUS:
                    prdata <= {24'h000000, ~below, irq_flag_q, 5'h00, wake_en_q};
                lvdr_pkg::OFF_ENABLE_LEVEL:
                    prdata <= {24'h000000, irq_en_q, det_on_q, level_q, 4'h0};
                lvdr_pkg::OFF_IRQ_STATUS:
                    prdata <= {29'h00000000, status_q};
                lvdr_pkg::OFF_IRQ_MASK:
                    prdata <= {29'h00000000, mask_q};
                lvdr_pkg::OFF_GLOBAL_IRQ:
                    prdata <= {31'h00000000, gie_q};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_flag_on_cross: assert property (@(posedge clk) disable iff (!rst_n)
        crossing |=> irq_flag_q) else $error("flag not set on crossing");
    a_state_off_high: assert property (@(posedge clk) disable iff (!rst_n)
        !det_on_q |-> !below) else $error("state low while detector off");
    a_vector_gate: assert property (@(posedge clk) disable iff (!rst_n)
        vector_req |-> $past(irq_flag_q & irq_en_q & gie_q)) else $error("vector without enables");
    a_wake_gate: assert property (@(posedge clk) disable iff (!rst_n)
        wake_req |-> $past(wake_en_q)) else $error("wake without enable");
    a_reset_clears: assert property (@(posedge clk)
        !rst_n |=> !irq_flag_q) else $error("flag survives reset");
    a_no_flag_above: assert property (@(posedge clk) disable iff (!rst_n)
        (!irq_flag_q && !below) |=> !irq_flag_q) else $error("flag set above level");
    a_short_dip: assert property (@(posedge clk) disable iff (!rst_n)
        (bor_st_q == BOR_DIP && dip_cnt_q < 16'(GRACE_CYCLES - 1)) |=> bor_st_q != BOR_RESET)
        else $error("reset before grace time");
    a_long_dip: assert property (@(posedge clk) disable iff (!rst_n)
        (bor_st_q == BOR_DIP && bor_low && dip_cnt_q >= 16'(GRACE_CYCLES - 1)) |=> ##1 sys_reset_req)
        else $error("no reset after grace time");
    a_sync_settle: assert property (@(posedge clk) disable iff (!rst_n)
        (s2_q[0] == s3_q[0]) |=> clean_q[0] == $past(s3_q[0])) else $error("filter bad");

    c_crossing: cover property (@(posedge clk) crossing);
    c_vector: cover property (@(posedge clk) vector_req);
    c_wake: cover property (@(posedge clk) wake_req);
    c_sys_reset: cover property (@(posedge clk) sys_reset_req);

endmodule

// ### inc/lvdr_pkg.sv
// Package for the low voltage detect and reset block.
// Holds register offsets, field positions, reset values and timing constants.
package lvdr_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] OFF_CTRL_STATUS = 8'h00; // Control and status (bank 0)
    localparam logic [7:0] OFF_ENABLE_LEVEL = 8'h04; // Enable and level (bank 1)
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08; // Sticky interrupt status
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C; // Interrupt mask
    localparam logic [7:0] OFF_GLOBAL_IRQ = 8'h10; // Global interrupt on/off

    // Control and status fields
    localparam int STATE_N_BIT = 7; // Live detector state, low when low
    localparam int IRQ_FLAG_BIT = 6; // Interrupt request flag
    localparam int WAKE_EN_BIT = 0; // Wake-up enable
    localparam int GIE_BIT = 0; // Global interrupt on, in its own word

    // Enable and level fields
    localparam int IRQ_EN_BIT = 7; // Individual interrupt enable
    localparam int DET_ON_BIT = 6; // Detector enable
    localparam int LEVEL_HI_BIT = 5; // Level field top bit
    localparam int LEVEL_LO_BIT = 4; // Level field bottom bit

    // Sticky status event bits
    localparam int EV_DETECT = 0; // Crossing below level
    localparam int EV_WAKE = 1; // Wake request raised
    localparam int EV_BROWNOUT = 2; // Brownout reset issued
    localparam int EV_WIDTH = 3; // Number of events

    // Detection level codes
    localparam logic [1:0] LVL_2V2 = 2'h3; // 2.2V
    localparam logic [1:0] LVL_3V3 = 2'h2; // 3.3V
    localparam logic [1:0] LVL_4V0 = 2'h1; // 4.0V
    localparam logic [1:0] LVL_4V5 = 2'h0; // 4.5V

    // Brownout option codes
    localparam logic [1:0] BOR_OFF = 2'h3; // Power-on reset only
    localparam logic [1:0] BOR_2V7 = 2'h2; // Reset 2.7V, release 2.9V
    localparam logic [1:0] BOR_3V5 = 2'h1; // Reset 3.5V, release 3.7V
    localparam logic [1:0] BOR_4V0 = 2'h0; // Reset 4.0V, release 4.2V

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h80; // State reads high, flag clear
    localparam logic [7:0] ENLVL_RESET = 8'h00; // All off, level 4.5V

    // Brownout grace time
    localparam int CLK_HZ = 20000000; // System clock rate
    localparam int GRACE_US = 80; // Dip shorter than this only halts
    localparam int GRACE_CYC = (GRACE_US * (CLK_HZ / 1000000)); // 1600 cycles

endpackage

// ### verif/lvdr_core_model.sv
// Behavioural model of the core's interrupt, sleep and reset logic.
// Assumes the supervisor outputs are registered on clk and stable between edges.
`timescale 1ns/1ps

module lvdr_core_model
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic vector_req, // Vector request from the supervisor
    input wire logic wake_req, // Wake request from the supervisor
    input wire logic sys_reset_req, // Full reset request
    input wire logic sleep_cmd, // Bench asks the core to execute a sleep
    output logic core_sleeping, // Core in sleep or idle
    output int vec_cnt // Vectors taken while awake
);
    ////////////////////////////////////////////////////////////////////////
    // Sleep state: only a wake or a reset ends it, as on the real core
    always_ff @(posedge clk)
    begin
        if (!rst_n || sys_reset_req)
            core_sleeping <= 1'b0;
        else if (wake_req)
            core_sleeping <= 1'b0;
        else if (sleep_cmd)
            core_sleeping <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector taken on the next instruction when the request stands
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            vec_cnt <= 0;
        else if (vector_req && !core_sleeping)
            vec_cnt <= vec_cnt + 1;
    end
endmodule

// ### verif/lvdr_top_tb.sv
// Self-checking bench for the supervisor: APB master, comparator stimulus,
// and the core model on the far side. Assumes the package constants.
`timescale 1ns/1ps

module lvdr_top_tb;
    logic clk, rst_n, psel, penable, pwrite, sleep_cmd; // Bench drives
    logic [7:0] paddr; // APB address
    logic [31:0] pwdata, prdata, rdat; // Write, read and captured data
    logic pready, pslverr, rerr, irq, vector_req, wake_req, halt_req, sys_reset_req;
    logic [1:0] brownout_level; // One-time option under test
    logic [3:0] det_below, bor_below, bor_above, dip; // Comparator levels
    logic core_sleeping; // From the core model
    int vec_cnt, n_mismatch, tests_run, seed, m_enlvl, hs, rs; // Model state
    logic ie; // Expected interrupt enable

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and core model
    always #25 clk = ~clk;

    lvdr_top #(.GRACE_CYCLES(8)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .brownout_level(brownout_level), .det_below(det_below),
        .bor_below(bor_below), .bor_above(bor_above), .core_sleeping(core_sleeping), .irq(irq),
        .vector_req(vector_req), .wake_req(wake_req), .halt_req(halt_req),
        .sys_reset_req(sys_reset_req));

    lvdr_core_model PM (.clk(clk), .rst_n(rst_n), .vector_req(vector_req), .wake_req(wake_req),
        .sys_reset_req(sys_reset_req), .sleep_cmd(sleep_cmd), .core_sleeping(core_sleeping),
        .vec_cnt(vec_cnt));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        seed = 96;
        {clk, rst_n, psel, penable, pwrite, sleep_cmd, paddr, pwdata} = '0;
        {n_mismatch, tests_run} = '0;
        det_below = 4'h0;
        bor_below = 4'h0;
        bor_above = 4'hF; // Supply well above every release level
        brownout_level = 2'({$random(seed)} % 4);
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        // Reset values of every mapped register, then an unmapped word
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rdat, (i == 0) ? 32'h80 : 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        // Detector off: live state stays high whatever the comparators say
        det_below <= 4'hF;
        cyc(8);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h80);
        det_below <= 4'h0;
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        // Every level code, interrupt enable off on the last one
        for (int l = 0; l < 4; l++)
        begin
            ie = (l != 3);
            m_enlvl = (int'(ie) << 7) | 32'h40 | (l << 4);
            apb(1'b1, 8'h04, m_enlvl);
            apb(1'b0, 8'h04, 32'h0);
            chk(rdat, m_enlvl);
            cyc(6);
            det_below <= (4'h1 << l) - 4'h1; // Falling, still above the level
            cyc(8);
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h80);
            det_below <= (4'h2 << l) - 4'h1; // Crossing of the chosen level
            cyc(8);
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h40);
            apb(1'b0, 8'h08, 32'h0);
            chk(rdat, 32'h1);
            chk({31'h0, irq}, 32'h1);
            chk({31'h0, vector_req}, {31'h0, ie});
            apb(1'b1, 8'h0C, 32'h0);
            cyc(2);
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, 8'h0C, 32'h1);
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h00);
            apb(1'b1, 8'h08, 32'h1);
            cyc(2);
            chk({31'h0, irq}, 32'h0);
            det_below <= 4'h0;
            cyc(8);
        end
        chk(32'(vec_cnt != 0), 32'h1);
        // Wake from sleep, first with wake-up disabled then enabled
        for (int w = 0; w < 2; w++)
        begin
            apb(1'b1, 8'h00, 32'(w));
            apb(1'b1, 8'h04, 32'h40);
            sleep_cmd <= 1'b1;
            cyc(1);
            sleep_cmd <= 1'b0;
            cyc(6);
            det_below <= 4'h1;
            hs = 0;
            repeat (10)
            begin
                @(posedge clk);
                hs = hs | int'(wake_req);
            end
            chk(32'(hs), 32'(w));
            chk({31'h0, core_sleeping}, 32'(1 - w));
            apb(1'b0, 8'h00, 32'h0);
            chk(rdat, 32'h40 | 32'(w));
            apb(1'b0, 8'h08, 32'h0);
            chk(rdat, 32'h1 | 32'(2 * w));
            apb(1'b1, 8'h00, 32'(w));
            apb(1'b1, 8'h08, 32'h7);
            det_below <= 4'h0;
            cyc(8);
        end
        // Brownout dips: one shorter than the grace count, one longer
        dip = (brownout_level == 2'h3) ? 4'h7 : (4'h1 << brownout_level);
        for (int d = 4; d <= 40; d += 36)
        begin
            hs = 0;
            rs = 0;
            bor_below <= dip;
            bor_above <= ~dip;
            for (int k = 0; k < 60; k++)
            begin
                if (k == d)
                begin
                    bor_below <= 4'h0;
                    bor_above <= 4'hF;
                end
                @(posedge clk);
                hs = hs | int'(halt_req);
                rs = rs | int'(sys_reset_req);
            end
            chk(32'(hs), 32'(brownout_level != 2'h3));
            chk(32'(rs), 32'(brownout_level != 2'h3 && d > 8));
            chk({31'h0, sys_reset_req}, 32'h0);
            apb(1'b0, 8'h04, 32'h0);
            chk(rdat, 32'h40);
        end
        // Flag set, then a system reset clears it
        det_below <= 4'h1;
        cyc(8);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h41);
        rst_n <= 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h80);
        wrap_up();
    end
endmodule
